// [pkg/rfe_pkg.sv]
package rfe_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_DEF_TABLE = 12'h008;
   localparam logic [11:0] REG_SEND_LEN = 12'h00C;
   localparam logic [11:0] REG_RX_STAT = 12'h010;
   localparam logic [11:0] REG_RX_LEN = 12'h014;
   localparam logic [11:0] REG_TX_STAT = 12'h018;
   localparam logic [11:0] REG_IRQ_STAT = 12'h01C;
   localparam logic [11:0] REG_IRQ_MASK = 12'h020;
   localparam logic [1:0] WIN_SEND = 2'h1;
   localparam logic [1:0] WIN_RECV = 2'h2;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTRL_RX_EXEC = 0;
   localparam int CTRL_TX_EXEC = 1;
   localparam int CTRL_RX_EN = 2;
   localparam int CTRL_RX_PORT = 3;
   localparam int CTRL_TX_PORT = 4;
   localparam int CTRL_ASCII = 5;
   localparam int CTRL_DEF_LSB = 8;
   localparam int DEF_IDX_LSB = 16;
   localparam int IRQ_RX_DONE = 0;
   localparam int IRQ_RX_FAULT = 1;
   localparam int IRQ_TX_DONE = 2;
   localparam int IRQ_TX_FAULT = 3;
   // ---------------------------------------------------------------
   // reset values, sizes and codes
   // ---------------------------------------------------------------
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] DEF_RESET = 16'h0000;
   localparam logic [8:0] SEND_LEN_RESET = 9'h000;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   localparam int NUM_DEFS = 128;
   localparam int BUF_DEPTH = 256;
   localparam logic [8:0] MAX_TX_LEN = 9'h0FF;
   localparam logic [8:0] RX_LIMIT = 9'h100;
   localparam logic [7:0] MODE_LEN = 8'h00;
   localparam logic [7:0] MODE_TERM = 8'h01;
   localparam logic [7:0] ST_OK = 8'h00;
   localparam logic [7:0] ST_PARAM = 8'h06;
   localparam logic [7:0] ST_NUMBER = 8'h08;
   localparam logic [7:0] ST_FRAME_TYPE = 8'h09;
   localparam logic [7:0] ASCII_DIGIT = 8'h30;
   localparam logic [7:0] ASCII_LETTER = 8'h37;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rfe_byte_t;
   typedef struct packed {
      logic [7:0] code;
      logic fault;
      logic done;
   } rfe_result_t;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b01,
      RX_RUN = 2'b10
   } rfe_rx_state_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_LOAD = 3'b010,
      TX_SHOW = 3'b100
   } rfe_tx_state_t;
endpackage

// [verilog/rfe_engine.sv]
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
// Behaviour
// - reception starts only on a rising edge of the receive execute bit, never on its level.
// - the port select picks channel 0 or 1 for reception, and software keeps to that range.
// - with end-condition upper byte 00 the lower byte is a length and the frame ends after that many bytes.
// - with end-condition upper byte 01 the lower byte is a terminator and the frame ends on a matching byte.
// - in terminator mode every byte up to and including the terminator is stored, the terminator in the same cycle that done is raised.
// - on completion the count of received bytes is written to the received length.
// - received bytes go into the receive buffer in arrival order from element zero.
// - reception only runs while the receive enable is on; nothing is taken while it is off.
// - the outcome of each attempt is shown as a code on the status output.
// - transmission of the send buffer starts on a rising edge of the transmit execute bit.
// - up to 128 frame definitions exist, each written at run time by a command.
// - in ascii coding each hex digit is carried as its ascii character, so 1234 goes out as 31 32 33 34.
// - done is set on clean completion, fault on error, and both hold until the next execute request.
// - a send length above 255 is refused with frame type error code 09.
module rfe_engine (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [rfe_pkg::ADDR_W-1:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [31:0] rd_data_out,
   output logic irq_out,
   input rfe_pkg::rfe_byte_t [1:0] ch_rx_in,
   output rfe_pkg::rfe_byte_t [1:0] ch_tx_out,
   input wire logic [1:0] ch_tx_ready_in
);
   import rfe_pkg::*;

   function automatic logic [7:0] hex_char(input logic [3:0] nib);
      hex_char = (nib < 4'hA) ? (ASCII_DIGIT + {4'h0, nib}) : (ASCII_LETTER + {4'h0, nib});
   endfunction

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0] send_buffer [BUF_DEPTH];
   logic [7:0] receive_buffer [BUF_DEPTH];
   logic [15:0] def_table [NUM_DEFS];

   logic [15:0] ctrl;
   logic [8:0] send_length;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   logic rx_exec_q;
   logic tx_exec_q;
   rfe_rx_state_t rx_state;
   rfe_tx_state_t tx_state;
   rfe_result_t rx_res;
   rfe_result_t tx_res;
   logic [15:0] end_condition_word;
   logic rx_port;
   logic [8:0] rx_cnt;
   logic [8:0] received_length;
   logic tx_port;
   logic tx_ascii;
   logic [7:0] tx_idx;
   logic tx_half;
   logic [7:0] tx_last;
   rfe_byte_t tx_byte;

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   wire [1:0] win = addr_in[11:10];
   wire [7:0] win_idx = addr_in[9:2];
   wire wr_ctrl = wr_en_in && (addr_in == REG_CTRL);
   wire wr_def = wr_en_in && (addr_in == REG_DEF_TABLE);
   wire wr_slen = wr_en_in && (addr_in == REG_SEND_LEN);
   wire wr_istat = wr_en_in && (addr_in == REG_IRQ_STAT);
   wire wr_imask = wr_en_in && (addr_in == REG_IRQ_MASK);
   wire wr_sbuf = wr_en_in && (win == WIN_SEND);
   wire [6:0] def_sel = ctrl[CTRL_DEF_LSB +: 7];
   wire [6:0] def_wr_idx = wr_data_in[DEF_IDX_LSB +: 7];
   wire [15:0] def_word = def_table[def_sel];
   wire [15:0] rx_stat_word = {rx_res.code, 6'h00, rx_res.fault, rx_res.done};
   wire [15:0] tx_stat_word = {tx_res.code, 6'h00, tx_res.fault, tx_res.done};
   logic [31:0] next_rd_data;
   always_comb begin
      next_rd_data = 32'h0000_0000;
      if (rd_en_in) begin
         if (win == WIN_RECV) begin
            next_rd_data = {24'h00_0000, receive_buffer[win_idx]};
         end else if (win == WIN_SEND) begin
            next_rd_data = {24'h00_0000, send_buffer[win_idx]};
         end else begin
            case (addr_in)
               REG_CTRL: next_rd_data = {16'h0000, ctrl};
               REG_DEF_TABLE: next_rd_data = {9'h000, def_sel, def_word};
               REG_SEND_LEN: next_rd_data = {23'h00_0000, send_length};
               REG_RX_STAT: next_rd_data = {16'h0000, rx_stat_word};
               REG_RX_LEN: next_rd_data = {23'h00_0000, received_length};
               REG_TX_STAT: next_rd_data = {16'h0000, tx_stat_word};
               REG_IRQ_STAT: next_rd_data = {28'h000_0000, irq_stat};
               REG_IRQ_MASK: next_rd_data = {28'h000_0000, irq_mask};
               default: next_rd_data = 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl <= CTRL_RESET;
         send_length <= SEND_LEN_RESET;
         irq_mask <= IRQ_MASK_RESET;
         rd_data_out <= 32'h0000_0000;
         rx_exec_q <= 1'b0;
         tx_exec_q <= 1'b0;
      end else begin
         if (wr_ctrl) ctrl <= wr_data_in[15:0];
         if (wr_slen) send_length <= wr_data_in[8:0];
         if (wr_imask) irq_mask <= wr_data_in[3:0];
         rd_data_out <= next_rd_data;
         rx_exec_q <= ctrl[CTRL_RX_EXEC];
         tx_exec_q <= ctrl[CTRL_TX_EXEC];
      end
   end

   // definitions are plain commands, not a reset-time table
   always_ff @(posedge clk_sys_in) begin
      if (wr_def) def_table[def_wr_idx] <= wr_data_in[15:0];
      if (wr_sbuf) send_buffer[win_idx] <= wr_data_in[7:0];
   end

   // ---------------------------------------------------------------
   // receive side
   // ---------------------------------------------------------------
   wire rx_en = ctrl[CTRL_RX_EN];
   wire rx_edge = ctrl[CTRL_RX_EXEC] && !rx_exec_q && rx_en;
   wire [7:0] def_mode = def_word[15:8];
   wire [7:0] def_low = def_word[7:0];
   wire [7:0] rx_mode = end_condition_word[15:8];
   wire [7:0] rx_low = end_condition_word[7:0];
   rfe_byte_t rx_byte;
   assign rx_byte = ch_rx_in[rx_port];
   wire rx_take = (rx_state == RX_RUN) && rx_en && rx_byte.valid;
   wire [8:0] rx_cnt_inc = rx_cnt + 9'h001;
   wire rx_len_hit = (rx_mode == MODE_LEN) && (rx_cnt_inc == {1'b0, rx_low});
   wire rx_term_hit = (rx_mode == MODE_TERM) && (rx_byte.data == rx_low);
   wire rx_finish = rx_take && (rx_len_hit || rx_term_hit);
   wire rx_overrun = rx_take && !rx_finish && (rx_cnt_inc == RX_LIMIT);
   wire def_bad_mode = (def_mode != MODE_LEN) && (def_mode != MODE_TERM);
   wire def_zero_len = (def_mode == MODE_LEN) && (def_low == 8'h00);
   wire rx_refuse = rx_edge && (def_bad_mode || def_zero_len);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_state <= RX_IDLE;
         rx_res <= '0;
         rx_cnt <= 9'h000;
         received_length <= 9'h000;
         end_condition_word <= DEF_RESET;
         rx_port <= 1'b0;
      end else begin
         case (rx_state)
            RX_IDLE: begin
               if (rx_edge) begin
                  rx_res <= '0;
                  rx_cnt <= 9'h000;
                  end_condition_word <= def_word;
                  rx_port <= ctrl[CTRL_RX_PORT];
                  if (def_bad_mode) begin
                     rx_res <= '{code: ST_PARAM, fault: 1'b1, done: 1'b0};
                  end else if (def_zero_len) begin
                     rx_res <= '{code: ST_NUMBER, fault: 1'b1, done: 1'b0};
                  end else begin
                     rx_state <= RX_RUN;
                  end
               end
            end
            RX_RUN: begin
               if (rx_take) rx_cnt <= rx_cnt_inc;
               if (rx_finish) begin
                  received_length <= rx_cnt_inc;
                  rx_res <= '{code: ST_OK, fault: 1'b0, done: 1'b1};
                  rx_state <= RX_IDLE;
               end else if (rx_overrun) begin
                  received_length <= rx_cnt_inc;
                  rx_res <= '{code: ST_NUMBER, fault: 1'b1, done: 1'b0};
                  rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // terminator itself is kept, so the frame reads back whole
   always_ff @(posedge clk_sys_in) begin
      if (rx_take) receive_buffer[rx_cnt[7:0]] <= rx_byte.data;
   end

   // ---------------------------------------------------------------
   // transmit side
   // ---------------------------------------------------------------
   wire tx_edge = ctrl[CTRL_TX_EXEC] && !tx_exec_q;
   wire tx_too_long = send_length > MAX_TX_LEN;
   wire tx_empty = send_length == 9'h000;
   wire [7:0] tx_raw = send_buffer[tx_idx];
   wire [7:0] tx_char = tx_half ? hex_char(tx_raw[3:0]) : hex_char(tx_raw[7:4]);
   wire [7:0] tx_pick = tx_ascii ? tx_char : tx_raw;
   wire tx_accept = (tx_state == TX_SHOW) && ch_tx_ready_in[tx_port];
   wire tx_byte_end = !tx_ascii || tx_half;
   wire tx_frame_end = tx_byte_end && (tx_idx == tx_last);

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_state <= TX_IDLE;
         tx_res <= '0;
         tx_idx <= 8'h00;
         tx_half <= 1'b0;
         tx_last <= 8'h00;
         tx_port <= 1'b0;
         tx_ascii <= 1'b0;
         tx_byte <= '0;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               if (tx_edge) begin
                  tx_res <= '0;
                  tx_idx <= 8'h00;
                  tx_half <= 1'b0;
                  tx_last <= send_length[7:0] - 8'h01;
                  tx_port <= ctrl[CTRL_TX_PORT];
                  tx_ascii <= ctrl[CTRL_ASCII];
                  if (tx_too_long) begin
                     tx_res <= '{code: ST_FRAME_TYPE, fault: 1'b1, done: 1'b0};
                  end else if (tx_empty) begin
                     tx_res <= '{code: ST_NUMBER, fault: 1'b1, done: 1'b0};
                  end else begin
                     tx_state <= TX_LOAD;
                  end
               end
            end
            TX_LOAD: begin
               tx_byte <= '{valid: 1'b1, data: tx_pick};
               tx_state <= TX_SHOW;
            end
            TX_SHOW: begin
               if (tx_accept) begin
                  tx_byte <= '0;
                  if (tx_frame_end) begin
                     tx_res <= '{code: ST_OK, fault: 1'b0, done: 1'b1};
                     tx_state <= TX_IDLE;
                  end else begin
                     tx_half <= tx_ascii && !tx_half;
                     if (tx_byte_end) tx_idx <= tx_idx + 8'h01;
                     tx_state <= TX_LOAD;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   generate
      for (genvar c = 0; c < 2; c++) begin : g_tx
         assign ch_tx_out[c] = (tx_port == 1'(c)) ? tx_byte : '0;
      end
   endgenerate

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   logic rx_done_q;
   logic rx_fault_q;
   logic tx_done_q;
   logic tx_fault_q;
   wire [3:0] irq_set = {tx_res.fault & ~tx_fault_q, tx_res.done & ~tx_done_q,
                         rx_res.fault & ~rx_fault_q, rx_res.done & ~rx_done_q};
   wire [3:0] irq_clr = wr_istat ? wr_data_in[3:0] : 4'h0;
   // set wins over a write-one-to-clear in the same cycle
   wire [3:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat <= 4'h0;
         irq_out <= 1'b0;
         rx_done_q <= 1'b0;
         rx_fault_q <= 1'b0;
         tx_done_q <= 1'b0;
         tx_fault_q <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_out <= |(next_irq_stat & irq_mask);
         rx_done_q <= rx_res.done;
         rx_fault_q <= rx_res.fault;
         tx_done_q <= tx_res.done;
         tx_fault_q <= tx_res.fault;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   a_rx_start_edge: assert property ($rose(rx_state == RX_RUN) |-> $past(rx_edge))
      else $error("receive started without an execute edge");
   a_rx_len_end: assert property (rx_finish && rx_mode == MODE_LEN |=> received_length == {1'b0, rx_low})
      else $error("length mode finished at wrong count");
   a_rx_term_end: assert property (rx_finish && rx_mode == MODE_TERM |-> rx_byte.data == rx_low ##1 rx_res.done)
      else $error("terminator mode finished on wrong byte");
   a_rx_len_report: assert property ($rose(rx_res.done) |-> received_length == rx_cnt)
      else $error("received length differs from stored bytes");
   a_rx_enable_gate: assert property (!rx_en |=> $stable(rx_cnt))
      else $error("byte taken while receive disabled");
   a_flag_clear: assert property (rx_edge && rx_state == RX_IDLE |=> !rx_res.done && rx_res.fault == $past(rx_refuse))
      else $error("flags survived a new request");
   a_tx_refuse: assert property (tx_edge && tx_state == TX_IDLE && tx_too_long |=>
      (tx_res.fault && tx_res.code == ST_FRAME_TYPE && tx_state == TX_IDLE) [*2])
      else $error("long send not refused with code 09");
   a_tx_start: assert property (tx_state == TX_LOAD && $past(tx_state == TX_IDLE) |-> $past(tx_edge))
      else $error("send started without an execute edge");
   a_tx_ascii: assert property (tx_byte.valid && tx_ascii |->
      (tx_byte.data >= 8'h30 && tx_byte.data <= 8'h39) || (tx_byte.data >= 8'h41 && tx_byte.data <= 8'h46))
      else $error("ascii send produced a non hex character");
   a_irq_level: assert property (irq_out == $past(|(next_irq_stat & irq_mask)))
      else $error("interrupt level out of step with status");
   // a byte on offer must not change before the partner takes it
   a_tx_hold: assert property (tx_byte.valid && !tx_accept |=> $stable(tx_byte))
      else $error("offered byte changed before it was taken");
   // each taken byte lands in the slot the count pointed at
   a_rx_store: assert property (rx_take |=> receive_buffer[$past(rx_cnt[7:0])] == $past(rx_byte.data))
      else $error("received byte stored out of order");

   c_rx_len_frame: cover property (rx_finish && rx_mode == MODE_LEN);
   c_rx_term_frame: cover property (rx_finish && rx_mode == MODE_TERM);
   c_tx_done: cover property ($rose(tx_res.done));
   c_tx_refused: cover property ($rose(tx_res.fault) && tx_res.code == ST_FRAME_TYPE);
endmodule

// [dv/rfe_partner.sv]
`timescale 1ns/1ns
module rfe_partner (
   input wire logic clk_in,
   input rfe_pkg::rfe_byte_t [1:0] tx_in,
   output rfe_pkg::rfe_byte_t [1:0] rx_out,
   output logic [1:0] ready_out
);
   import rfe_pkg::*;
   // ---------------------------------------------------------------
   // serial instrument stand-in
   // ---------------------------------------------------------------
   logic [8:0] got_q[$];
   logic slow = 1'b0;
   initial begin
      rx_out = '0;
      ready_out = 2'b00;
   end
   // one valid pulse per byte; idle line shows the inverse, never a stale copy
   task automatic put_byte(input logic port, input logic [7:0] b);
      @(posedge clk_in);
      rx_out[port] <= {1'b1, b};
      @(posedge clk_in);
      rx_out[port] <= {1'b0, ~b};
   endtask
   // slow mode stalls at random to stretch the hold of each byte
   always @(posedge clk_in) begin
      ready_out <= slow ? 2'($urandom) : 2'b11;
      for (int p = 0; p < 2; p++) begin
         if (tx_in[p].valid && ready_out[p]) begin
            got_q.push_back({p[0], tx_in[p].data});
         end
      end
   end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ns
module testbench;
   import rfe_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and bookkeeping
   // ---------------------------------------------------------------
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [11:0] addr_in = '0;
   logic [31:0] wr_data_in = '0;
   logic wr_en_in = 1'b0;
   logic rd_en_in = 1'b0;
   logic [31:0] rd_data_out;
   logic irq_out;
   rfe_byte_t [1:0] ch_rx_in;
   rfe_byte_t [1:0] ch_tx_out;
   logic [1:0] ch_tx_ready_in;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   int last_len = 0;
   logic [11:0] rst_regs [7] = '{REG_CTRL, REG_SEND_LEN, REG_RX_STAT, REG_RX_LEN, REG_TX_STAT, REG_IRQ_STAT,
      REG_IRQ_MASK};
   logic [31:0] d;
   logic [7:0] src_q[$];
   logic [8:0] exp_q[$];
   logic [7:0] term;
   logic port;
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   rfe_engine dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
      .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .irq_out(irq_out),
      .ch_rx_in(ch_rx_in), .ch_tx_out(ch_tx_out), .ch_tx_ready_in(ch_tx_ready_in));
   rfe_partner partner (.clk_in(clk_sys_in), .tx_in(ch_tx_out), .rx_out(ch_rx_in), .ready_out(ch_tx_ready_in));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // a hung handshake must still reach the verdict
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 60000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk_sys_in);
      wr_en_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= v;
      @(posedge clk_sys_in);
      wr_en_in <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [11:0] a);
      @(posedge clk_sys_in);
      rd_en_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_en_in <= 1'b0;
      #1 d = rd_data_out;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      rd(a);
      chk(what, exp, d);
   endtask
   function automatic logic [31:0] ctrl_w(logic rx_x, logic tx_x, logic en, logic p, logic asc, logic [6:0] idx);
      return {17'h0, idx, 2'h0, asc, p, p, en, tx_x, rx_x};
   endfunction
   function automatic logic [7:0] hexch(logic [3:0] v);
      return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
   endfunction
   function automatic logic [31:0] stat_w(logic [7:0] code);
      return (code == 8'h00) ? 32'h0000_0001 : {16'h0, code, 8'h02};
   endfunction
   // bytes in src_q go out on the line; only nst of them are expected to be stored
   task automatic rx_frame(input logic [15:0] cond, input logic [7:0] code, input int nst);
      wr(REG_DEF_TABLE, {9'h0, 7'h05, cond});
      wr(REG_CTRL, ctrl_w(1'b0, 1'b0, 1'b1, port, 1'b0, 7'h05));
      wr(REG_CTRL, ctrl_w(1'b1, 1'b0, 1'b1, port, 1'b0, 7'h05));
      repeat (3) @(posedge clk_sys_in);
      partner.put_byte(~port, 8'hA5);
      foreach (src_q[i]) partner.put_byte(port, src_q[i]);
      repeat (3) @(posedge clk_sys_in);
      rd_chk(REG_RX_STAT, stat_w(code), "rx status");
      // a refused request leaves the last completed length in place
      if (code == 8'h00) last_len = nst;
      rd_chk(REG_RX_LEN, 32'(last_len), "rx length");
      for (int i = 0; i < nst; i++) rd_chk(12'h800 + 12'(4 * i), 32'(src_q[i]), "rx byte");
   endtask
   task automatic tx_frame(input logic asc, input logic [8:0] len, input logic [7:0] code);
      foreach (src_q[i]) wr(12'h400 + 12'(4 * i), 32'(src_q[i]));
      exp_q.delete();
      if (code == 8'h00) begin
         foreach (src_q[i]) begin
            if (asc) begin
               exp_q.push_back({port, hexch(src_q[i][7:4])});
               exp_q.push_back({port, hexch(src_q[i][3:0])});
            end else begin
               exp_q.push_back({port, src_q[i]});
            end
         end
      end
      partner.got_q.delete();
      partner.slow = 1'($urandom);
      wr(REG_SEND_LEN, 32'(len));
      wr(REG_CTRL, ctrl_w(1'b0, 1'b0, 1'b0, port, asc, 7'h00));
      wr(REG_CTRL, ctrl_w(1'b0, 1'b1, 1'b0, port, asc, 7'h00));
      for (int k = 0; k < 3000; k++) begin
         rd(REG_TX_STAT);
         if (d[1:0] != 2'b00) break;
      end
      chk("tx status", stat_w(code), d);
      chk("tx count", exp_q.size(), partner.got_q.size());
      foreach (exp_q[i]) chk("tx byte", 32'(exp_q[i]), 32'(partner.got_q[i]));
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h4C0B));
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      foreach (rst_regs[i]) rd_chk(rst_regs[i], 32'h0, "reset value");
      wr(12'h004, 32'hFFFF_FFFF);
      rd_chk(12'h004, 32'h0, "unmapped");
      wr(REG_DEF_TABLE, {9'h0, 7'h7F, 16'h0105});
      wr(REG_DEF_TABLE, {9'h0, 7'h00, 16'h0007});
      wr(REG_CTRL, ctrl_w(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h7F));
      rd_chk(REG_DEF_TABLE, {9'h0, 7'h7F, 16'h0105}, "definition 127");
      wr(REG_CTRL, ctrl_w(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h00));
      rd_chk(REG_DEF_TABLE, {9'h0, 7'h00, 16'h0007}, "definition 0");
      wr(REG_IRQ_MASK, 32'h0000_000F);
      for (int t = 0; t < 4; t++) begin
         port = t[0];
         src_q.delete();
         repeat ((t == 0) ? 1 : 1 + $urandom % 6) src_q.push_back(8'($urandom));
         rx_frame({MODE_LEN, 8'(src_q.size())}, 8'h00, src_q.size());
         chk("irq on done", 32'h1, 32'(irq_out));
         rd_chk(REG_IRQ_STAT, 32'h1, "irq status");
         wr(REG_IRQ_STAT, 32'h1);
         repeat (2) @(posedge clk_sys_in);
         chk("irq cleared", 32'h0, 32'(irq_out));
         term = 8'($urandom);
         src_q.delete();
         repeat (1 + $urandom % 8) src_q.push_back(8'($urandom) ^ ((8'($urandom) == term) ? 8'h00 : 8'h00));
         foreach (src_q[i]) if (src_q[i] == term) src_q[i] = ~term;
         src_q.push_back(term);
         rx_frame({MODE_TERM, term}, 8'h00, src_q.size());
      end
      src_q.delete();
      rx_frame(16'h0203, 8'h06, 0);
      rx_frame(16'h0000, 8'h08, 0);
      wr(REG_IRQ_STAT, 32'hF);
      port = 1'b0;
      wr(REG_DEF_TABLE, {9'h0, 7'h05, 16'h0002});
      wr(REG_CTRL, ctrl_w(1'b0, 1'b0, 1'b1, port, 1'b0, 7'h05));
      wr(REG_CTRL, ctrl_w(1'b1, 1'b0, 1'b1, port, 1'b0, 7'h05));
      repeat (3) @(posedge clk_sys_in);
      partner.put_byte(port, 8'h3C);
      wr(REG_CTRL, ctrl_w(1'b1, 1'b0, 1'b0, port, 1'b0, 7'h05));
      partner.put_byte(port, 8'hEE);
      wr(REG_CTRL, ctrl_w(1'b1, 1'b0, 1'b1, port, 1'b0, 7'h05));
      partner.put_byte(port, 8'hC3);
      repeat (3) @(posedge clk_sys_in);
      rd_chk(REG_RX_LEN, 32'h2, "paused length");
      rd_chk(12'h804, 32'hC3, "paused byte");
      wr(REG_CTRL, ctrl_w(1'b1, 1'b0, 1'b1, port, 1'b0, 7'h05));
      partner.put_byte(port, 8'h99);
      repeat (3) @(posedge clk_sys_in);
      rd_chk(REG_RX_LEN, 32'h2, "level held");
      rd_chk(REG_RX_STAT, 32'h1, "done held");
      port = 1'($urandom);
      src_q.delete();
      repeat (1 + $urandom % 6) src_q.push_back(8'($urandom));
      tx_frame(1'b0, 9'(src_q.size()), 8'h00);
      src_q = '{8'h12, 8'h34, 8'hAB};
      tx_frame(1'b1, 9'h003, 8'h00);
      src_q.delete();
      repeat (255) src_q.push_back(8'($urandom));
      tx_frame(1'b0, 9'h0FF, 8'h00);
      src_q.delete();
      wr(REG_IRQ_MASK, 32'h0);
      wr(REG_IRQ_STAT, 32'hF);
      tx_frame(1'b0, 9'h100, 8'h09);
      tx_frame(1'b0, 9'h000, 8'h08);
      chk("irq masked", 32'h0, 32'(irq_out));
      wr(REG_IRQ_MASK, 32'h8);
      repeat (2) @(posedge clk_sys_in);
      chk("irq unmasked", 32'h1, 32'(irq_out));
      stop_test();
   end
endmodule
